// ===== ogt_regs.svh
// Register offsets, field positions, reset values and timing counts
// How it works
// - 8-bit counter counts selected divided clock pulses while run bit is set
// - Wrap from FF to 00 is overflow; response depends on mode bit
// - Counter resets to zero
// - Interval flag bit 7 sets on overflow in interval mode only
// - Interval flag clears by read-1-then-write-0, or run bit cleared
// - Mode bit 6: 0 interval interrupt, 1 guard overflow pulse
// - Run bit 5 starts counting; when 0 counter held at zero except in standby
// - Control bits 4 and 3 read as one; software writes one
// - Clock select codes pick divide by 2,64,128,256,512,1024,4096,8192
// - Guard flag sets on guard overflow, clears by read-1-then-write-0
// - Reset enable gates chip reset; counter and control always reset
// - Reset type bit: 0 power-on reset, 1 manual reset
// - Reset control bits 4 to 0 read as one
// - Guard overflow drives external overflow low for 128 cycles
// - Chip reset starts with overflow pulse and lasts 512 cycles
// - Reset pin wins over guard reset and clears guard flag
// - Block reset is flagged distinct from external power-on reset
// - Interval overflow sets flag and interrupt request together
// - Standby refused while run bit set
// - On standby wake, counter runs; overflow ends standby
// - Word writes with key 5A to counter, A5 to control
// - Reset control: A5 with 00 clears flag, 5A loads bits 6,5
// - Counter write beats a same-cycle increment
`ifndef OGT_REGS_SVH
`define OGT_REGS_SVH
`define OGT_RD_CTRL       2'h0
`define OGT_RD_CNT        2'h1
`define OGT_RD_RST        2'h3
`define OGT_WR_CNT_CTRL   1'b0
`define OGT_WR_RST        1'b1
`define OGT_KEY_CNT       8'h5A
`define OGT_KEY_CTRL      8'hA5
`define OGT_BIT_FLAG      7
`define OGT_BIT_MODE      6
`define OGT_BIT_RUN       5
`define OGT_BIT_TYPE      5
`define OGT_CTRL_ONES     8'h18
`define OGT_RST_ONES      8'h1F
`define OGT_CNT_RESET     8'h00
`define OGT_CNT_MAX       8'hFF
`define OGT_CLK_MHZ       200
`define OGT_OVF_PULSE_CYC 128
`define OGT_CHIP_RST_CYC  512
`define OGT_PRE_W         13
`endif

// ===== ogt_pkg.sv
// Types shared by the guard timer files
package ogt_pkg;
    typedef struct packed {
        logic       flag;
        logic       mode;
        logic       run;
        logic [2:0] clk_sel;
    } ogt_ctrl_t;
    typedef struct packed {
        logic flag;
        logic enable;
        logic rtype;
    } ogt_rst_t;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] rd_addr;
        logic       wr_sel;
        logic [15:0] wdata;
    } ogt_bus_t;
    typedef enum logic [1:0] {OGT_IDLE, OGT_GUARD_OUT, OGT_RST_ONLY} ogt_state_t;
endpackage

// ===== ogt_prescaler.sv
// Run-gated divider, cleared while stopped, and divided-clock tick selection
`timescale 1ns/1ps
`default_nettype none
`include "ogt_regs.svh"
module ogt_prescaler (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    output logic            tick
);
    logic [`OGT_PRE_W-1:0] div_ff;
    logic [`OGT_PRE_W-1:0] nxt_div;
    logic [7:0]            tap;
    // Tap bit index per code; ticks on the all-ones phase of that bit
    localparam logic [3:0] TAP_IDX [8] = '{4'h0, 4'h5, 4'h6, 4'h7,
                                           4'h8, 4'h9, 4'hB, 4'hC};
    // Divider is cleared while stopped so each start counts a full period
    assign nxt_div = run ? div_ff + 1'b1 : '0;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end
    // One pulse per 2^(idx+1) cycles for each selectable rate
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_tap
            assign tap[g] = &div_ff[TAP_IDX[g]:0];
        end
    endgenerate
    assign tick = run & tap[clk_sel];
endmodule // ogt_prescaler
`default_nettype wire

// ===== ogt_guard_timer.sv
// Overflow guard timer: keyed registers, counter, overflow responses
`timescale 1ns/1ps
`default_nettype none
`include "ogt_regs.svh"
module ogt_guard_timer (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire ogt_pkg::ogt_bus_t bus,
    input  wire logic              external_reset_pin_n,
    input  wire logic              standby_request,
    input  wire logic              standby_active,
    output logic [7:0]             rdata,
    output logic                   interval_interrupt_request,
    output logic                   external_overflow_out_n,
    output logic                   chip_reset_req,
    output logic                   chip_reset_manual,
    output logic                   chip_reset_from_guard,
    output logic                   standby_allowed,
    output logic                   standby_release
);
    import ogt_pkg::*;

    ogt_ctrl_t  ctrl_ff;
    ogt_rst_t   rst_ff;
    logic [7:0] cnt_ff;
    logic       ovf_seen_ff;
    logic       guard_overflow_flag_seen_ff;
    logic [8:0] pulse_ff;
    logic [9:0] rcnt_ff;
    ogt_state_t st_ff;
    logic [7:0] rdata_ff;
    logic       tick;

    // Checker timing: all properties below sample on the rising edge
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Access decode
    wire [7:0] key     = bus.wdata[15:8];
    wire [7:0] low     = bus.wdata[7:0];
    wire wr_cnt  = bus.wr && bus.wr_sel == `OGT_WR_CNT_CTRL
                   && key == `OGT_KEY_CNT;
    wire wr_ctrl = bus.wr && bus.wr_sel == `OGT_WR_CNT_CTRL
                   && key == `OGT_KEY_CTRL;
    wire wr_rclr = bus.wr && bus.wr_sel == `OGT_WR_RST
                   && key == `OGT_KEY_CTRL && low == 8'h00;
    wire wr_rcfg = bus.wr && bus.wr_sel == `OGT_WR_RST
                   && key == `OGT_KEY_CNT;
    wire rd_ctrl = bus.rd && bus.rd_addr == `OGT_RD_CTRL;
    wire rd_rst  = bus.rd && bus.rd_addr == `OGT_RD_RST;

    // Standby keeps the count going so its overflow can end the standby
    wire cnt_en = ctrl_ff.run || standby_active;

    ogt_prescaler u_pre (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (cnt_en),
        .clk_sel (ctrl_ff.clk_sel),
        .tick    (tick)
    );

    // Overflow and its routing by mode
    wire ovf       = tick && !wr_cnt && cnt_ff == `OGT_CNT_MAX;
    wire ovf_int   = ovf && !ctrl_ff.mode;
    wire ovf_guard = ovf && ctrl_ff.mode;
    wire pin_rst   = !external_reset_pin_n;

    // Counter: write beats increment, stop forces zero
    wire [7:0] nxt_cnt = !cnt_en ? `OGT_CNT_RESET
                       : wr_cnt ? low
                       : tick ? cnt_ff + 8'h01 : cnt_ff;
    // Guard overflow without reset enable still resets counter and control
    wire self_clear = ovf_guard;

    // Interval flag: set wins over clear
    wire ovf_clr = (wr_ctrl && !low[`OGT_BIT_FLAG] && ovf_seen_ff)
                   || (wr_ctrl && !low[`OGT_BIT_RUN] && !ctrl_ff.mode);
    wire nxt_oflag = ovf_int | (ctrl_ff.flag & ~ovf_clr);

    // Guard flag: pin reset wins, then set, then read-gated clear
    wire nxt_wflag = pin_rst ? 1'b0
                   : ovf_guard ? 1'b1
                   : (wr_rclr && guard_overflow_flag_seen_ff) ? 1'b0
                   : rst_ff.flag;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= `OGT_CNT_RESET;
        end else begin
            cnt_ff <= self_clear ? `OGT_CNT_RESET : nxt_cnt;
        end
    end

    // Control register; bits 4,3 are constants on read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= '0;
        end else if (self_clear) begin
            ctrl_ff <= '0;
        end else begin
            ctrl_ff.flag <= nxt_oflag;
            if (wr_ctrl) begin
                ctrl_ff.mode    <= low[`OGT_BIT_MODE];
                ctrl_ff.run     <= low[`OGT_BIT_RUN];
                ctrl_ff.clk_sel <= low[2:0];
            end
        end
    end

    // Reset control register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_ff <= '0;
        end else begin
            rst_ff.flag <= nxt_wflag;
            if (wr_rcfg) begin
                rst_ff.enable <= low[`OGT_BIT_MODE];
                rst_ff.rtype  <= low[`OGT_BIT_TYPE];
            end
        end
    end

    // Read-as-one tracking arms the zero-write clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovf_seen_ff  <= 1'b0;
            guard_overflow_flag_seen_ff <= 1'b0;
        end else begin
            ovf_seen_ff  <= ovf_int ? 1'b0 : (rd_ctrl && ctrl_ff.flag)
                            ? 1'b1 : (nxt_oflag ? ovf_seen_ff : 1'b0);
            guard_overflow_flag_seen_ff <= ovf_guard ? 1'b0 : (rd_rst && rst_ff.flag)
                            ? 1'b1 : (nxt_wflag ? guard_overflow_flag_seen_ff : 1'b0);
        end
    end

    // Pulse timers; pin reset aborts an in-flight guard reset
    logic [8:0] nxt_pulse;
    logic [9:0] nxt_rcnt;
    ogt_state_t nxt_st;
    always_comb begin
        nxt_pulse = (pulse_ff != '0) ? pulse_ff - 9'd1 : '0;
        nxt_rcnt  = (rcnt_ff != '0) ? rcnt_ff - 10'd1 : '0;
        nxt_st    = st_ff;
        case (st_ff)
            OGT_IDLE: begin
                if (ovf_guard) begin
                    nxt_pulse = 9'(`OGT_OVF_PULSE_CYC);
                    nxt_st    = OGT_GUARD_OUT;
                    if (rst_ff.enable && !pin_rst) begin
                        nxt_rcnt = 10'(`OGT_CHIP_RST_CYC);
                    end
                end
            end
            OGT_GUARD_OUT: begin
                if (nxt_pulse == '0 && nxt_rcnt == '0) begin
                    nxt_st = OGT_IDLE;
                end else if (nxt_pulse == '0) begin
                    nxt_st = OGT_RST_ONLY;
                end
            end
            default: begin
                if (nxt_rcnt == '0) begin
                    nxt_st = OGT_IDLE;
                end
            end
        endcase
        if (pin_rst) begin
            nxt_rcnt = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_ff <= '0;
            rcnt_ff  <= '0;
            st_ff    <= OGT_IDLE;
        end else begin
            pulse_ff <= nxt_pulse;
            rcnt_ff  <= nxt_rcnt;
            st_ff    <= nxt_st;
        end
    end

    // Read data from a register; reserved bits read as one
    wire [7:0] ctrl_rd = {ctrl_ff.flag, ctrl_ff.mode, ctrl_ff.run,
                          2'b00, ctrl_ff.clk_sel} | `OGT_CTRL_ONES;
    wire [7:0] rst_rd  = {rst_ff.flag, rst_ff.enable, rst_ff.rtype,
                          5'h00} | `OGT_RST_ONES;
    wire [7:0] nxt_rdata = rd_ctrl ? ctrl_rd
                         : (bus.rd && bus.rd_addr == `OGT_RD_CNT) ? cnt_ff
                         : rd_rst ? rst_rd
                         : 8'h00;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata = rdata_ff;

    // Outputs
    assign interval_interrupt_request = ctrl_ff.flag;
    assign external_overflow_out_n    = (pulse_ff == '0);
    assign chip_reset_req             = (rcnt_ff != '0);
    assign chip_reset_manual          = rst_ff.rtype;
    // Separate source line so pin and port registers skip this reset
    assign chip_reset_from_guard      = (rcnt_ff != '0);
    assign standby_allowed = standby_request && !ctrl_ff.run;
    // Standby wake: overflow marks oscillator settled
    assign standby_release = standby_active && ovf;

    // Checker helpers: run lengths of the guard pulse and the chip reset
    logic [8:0] chk_low_len_ff;
    logic [9:0] chk_rst_len_ff;
    wire  [8:0] nxt_chk_low_len = !external_overflow_out_n
                                  ? chk_low_len_ff + 9'h001 : 9'h000;
    wire  [9:0] nxt_chk_rst_len = chip_reset_req
                                  ? chk_rst_len_ff + 10'h001 : 10'h000;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chk_low_len_ff <= 9'h000;
            chk_rst_len_ff <= 10'h000;
        end else begin
            chk_low_len_ff <= nxt_chk_low_len;
            chk_rst_len_ff <= nxt_chk_rst_len;
        end
    end

    // Counter and interval flag checks
    a_int_flag_sets: assert property (
        ovf_int |=> ctrl_ff.flag)
        else $error("interval flag not set");
    a_no_int_guard: assert property (
        ovf_guard |=> !ctrl_ff.flag)
        else $error("flag in guard mode");
    a_run_clear_flag: assert property (
        wr_ctrl && !low[`OGT_BIT_RUN] && !ctrl_ff.mode && !ovf_int |=> !ctrl_ff.flag)
        else $error("run clear kept flag");
    a_int_clear_gated: assert property (
        wr_ctrl && ctrl_ff.flag && !ovf_seen_ff && low[`OGT_BIT_RUN]
        && !self_clear |=> ctrl_ff.flag) else $error("unarmed flag clear");
    a_stop_zeroes: assert property (
        !cnt_en |=> cnt_ff == 8'h00)
        else $error("stopped nonzero");
    a_count_step: assert property (
        tick && cnt_en && !wr_cnt && !self_clear |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("counter did not advance");
    a_wrap_zero: assert property (
        ovf |=> cnt_ff == 8'h00)
        else $error("overflow did not wrap");
    a_write_wins: assert property (
        wr_cnt && ctrl_ff.run && !self_clear |=> cnt_ff == $past(low))
        else $error("counter write lost");

    // Guard response checks
    a_guard_flag_sets: assert property (
        ovf_guard && !pin_rst |=> rst_ff.flag)
        else $error("guard flag not set");
    a_clear_gated: assert property (
        wr_rclr && rst_ff.flag && !guard_overflow_flag_seen_ff && !pin_rst |=> rst_ff.flag)
        else $error("unarmed guard clear");
    a_guard_reset_ctrl: assert property (
        ovf_guard |=> cnt_ff == 8'h00 && !ctrl_ff.run && !ctrl_ff.mode)
        else $error("counter or control kept");
    a_no_reset_disabled: assert property (
        ovf_guard && !rst_ff.enable && !chip_reset_req |=> !chip_reset_req)
        else $error("chip reset while disabled");
    a_pulse_width: assert property (
        ovf_guard |=> !external_overflow_out_n[*8] ##121 external_overflow_out_n)
        else $error("pulse width wrong");
    a_pulse_length: assert property (
        external_overflow_out_n && chk_low_len_ff != 9'h000 |-> chk_low_len_ff == 9'h080)
        else $error("pulse length wrong");
    a_reset_start: assert property (
        ovf_guard && rst_ff.enable && !pin_rst |=>
        chip_reset_req && !external_overflow_out_n)
        else $error("chip reset not with pulse");
    a_reset_width: assert property (
        !chip_reset_req && chk_rst_len_ff != 10'h000
        && $past(external_reset_pin_n) |-> chk_rst_len_ff == 10'h200)
        else $error("chip reset length wrong");
    a_pin_wins: assert property (
        pin_rst |=> !rst_ff.flag && !chip_reset_req)
        else $error("pin reset lost");

    // Read-back and standby checks
    a_ones_read: assert property (
        rd_ctrl |=> rdata[4:3] == 2'b11)
        else $error("reserved bits");
    a_rst_ones_read: assert property (
        rd_rst |=> rdata[4:0] == 5'h1F)
        else $error("reset reserved bits");
    a_standby_run: assert property (
        ctrl_ff.run |-> !standby_allowed)
        else $error("standby in run");

    // Main scenarios
    c_interval: cover property (ovf_int);
    c_guard: cover property (ovf_guard);
    c_chip_rst: cover property ($rose(chip_reset_req));
    c_standby_wake: cover property (standby_release);
    c_pin_abort: cover property (pin_rst && ovf_guard);
endmodule // ogt_guard_timer
`default_nettype wire

// ===== ogt_standby_model.sv
// Standby controller model facing the guard timer
`timescale 1ns/1ps
`default_nettype none
module ogt_standby_model (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic standby_request,
    input  wire logic standby_allowed,
    input  wire logic standby_release,
    output logic      standby_active
);
    // Enter only when permitted; leave on the settle signal
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            standby_active <= 1'b0;
        end else if (standby_release) begin
            standby_active <= 1'b0;
        end else if (standby_request && standby_allowed) begin
            standby_active <= 1'b1;
        end
    end
endmodule // ogt_standby_model
`default_nettype wire

// ===== overflow_guard_timer_tb.sv
// Self-checking testbench for the overflow guard timer
`timescale 1ns/1ps
`default_nettype none
module overflow_guard_timer_tb;
    import ogt_pkg::*;
    logic       clk;
    logic       reset_n;
    ogt_bus_t   bus;
    logic       pin_n;
    logic       stb_req;
    logic       stb_act;
    logic [7:0] rdata;
    logic       irq;
    logic       ovf_n;
    logic       rst_req;
    logic       rst_man;
    logic       rst_grd;
    logic       stb_ok;
    logic       stb_rel;
    logic [7:0] v;
    logic [7:0] d;
    logic [7:0] key;
    int         bad_count;
    int         total_checks;
    int         n_o;
    int         n_r;
    int         k;

    ogt_guard_timer dut (.clk(clk), .reset_n(reset_n), .bus(bus),
        .external_reset_pin_n(pin_n), .standby_request(stb_req),
        .standby_active(stb_act), .rdata(rdata),
        .interval_interrupt_request(irq), .external_overflow_out_n(ovf_n),
        .chip_reset_req(rst_req), .chip_reset_manual(rst_man),
        .chip_reset_from_guard(rst_grd), .standby_allowed(stb_ok),
        .standby_release(stb_rel));
    ogt_standby_model partner (.clk(clk), .reset_n(reset_n),
        .standby_request(stb_req), .standby_allowed(stb_ok),
        .standby_release(stb_rel), .standby_active(stb_act));

    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Word write: key in the high byte, data in the low byte
    task automatic wr(input logic s, input logic [7:0] ky, input logic [7:0] dt);
        @(negedge clk);
        bus.wr = 1'b1;
        bus.wr_sel = s;
        bus.wdata = {ky, dt};
        @(negedge clk);
        bus.wr = 1'b0;
    endtask

    // Read data lands one cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        @(negedge clk);
        bus.rd = 1'b1;
        bus.rd_addr = a;
        @(negedge clk);
        q = rdata;
        bus.rd = 1'b0;
    endtask

    function automatic int div_of(input int c);
        int t[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
        return t[c];
    endfunction

    function automatic logic [7:0] rst_val(input logic f, e, t);
        return {f, e, t, 5'h1F};
    endfunction

    // One guard overflow with the given reset enable and type
    task automatic guard(input logic e, input logic t);
        wr(1'b1, 8'h5A, {1'b0, e, t, 5'h1F});
        wr(1'b0, 8'hA5, 8'h78);
        wr(1'b0, 8'h5A, 8'hF0);
        repeat (16) @(negedge clk);
        wr(1'b0, 8'h5A, 8'h00);
        check(ovf_n, 1'b1);
        wr(1'b0, 8'h5A, 8'hFE);
        for (k = 0; k < 20 && ovf_n === 1'b1; k++) @(negedge clk);
        check(rst_req, e);
        check(rst_grd, e);
        check(rst_man, t);
        n_o = 0;
        n_r = 0;
        repeat (700) begin
            if (ovf_n === 1'b0) n_o++;
            if (rst_req === 1'b1) n_r++;
            @(negedge clk);
        end
        check(n_o, 128);
        check(n_r, e ? 512 : 0);
        check(irq, 1'b0);
        wr(1'b1, 8'hA5, 8'h00);
        rd(2'h3, v);
        check(v, rst_val(1'b1, e, t));
        rd(2'h0, v);
        check(v, 8'h18);
        wr(1'b1, 8'hA5, 8'h00);
        rd(2'h3, v);
        check(v, rst_val(1'b0, e, t));
    endtask

    // Watchdog cuts a hang short
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial begin
        bad_count = 0;
        total_checks = 0;
        reset_n = 1'b0;
        bus = '0;
        pin_n = 1'b1;
        stb_req = 1'b0;
        v = 8'($urandom(32'hD9ACF933));
        repeat (20) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        rd(2'h0, v);
        check(v, 8'h18);
        rd(2'h1, v);
        check(v, 8'h00);
        rd(2'h3, v);
        check(v, 8'h1F);
        // Interval overflow, flag arming and clearing
        wr(1'b0, 8'hA5, 8'h38);
        wr(1'b0, 8'h5A, 8'hFE);
        for (k = 0; k < 20 && irq !== 1'b1; k++) @(negedge clk);
        check(irq, 1'b1);
        wr(1'b0, 8'hA5, 8'h38);
        check(irq, 1'b1);
        rd(2'h0, v);
        check(v, 8'hB8);
        wr(1'b0, 8'hA5, 8'h38);
        check(irq, 1'b0);
        for (k = 0; k < 600 && irq !== 1'b1; k++) @(negedge clk);
        check(irq, 1'b1);
        wr(1'b0, 8'hA5, 8'h18);
        check(irq, 1'b0);
        rd(2'h1, v);
        check(v, 8'h00);
        // Counter read-back under random keys at the slowest rate
        wr(1'b0, 8'hA5, 8'h3F);
        repeat (4) begin
            d = 8'($urandom);
            key = 8'($urandom);
            if (key == 8'h5A || key == 8'hA5) key = 8'h00;
            wr(1'b0, 8'h5A, d);
            wr(1'b0, key, d + 8'h01);
            rd(2'h1, v);
            check(v, d);
        end
        // Every clock-select code, ticks counted over 2.5 periods
        for (int c = 0; c < 8; c++) begin
            wr(1'b0, 8'hA5, 8'h18 | 8'(c));
            wr(1'b0, 8'hA5, 8'h38 | 8'(c));
            repeat (div_of(c) * 5 / 2) @(negedge clk);
            rd(2'h1, v);
            check(v >= 8'h02 && v <= 8'h04, 1'b1);
        end
        // Standby refused while running, ended by an overflow
        stb_req = 1'b1;
        @(negedge clk);
        check(stb_ok, 1'b0);
        wr(1'b0, 8'hA5, 8'h18);
        @(negedge clk);
        check(stb_act, 1'b1);
        stb_req = 1'b0;
        rd(2'h0, v);
        check(v, 8'h18);
        for (k = 0; k < 600 && stb_rel !== 1'b1; k++) @(negedge clk);
        check(stb_rel, 1'b1);
        @(negedge clk);
        check(stb_act, 1'b0);
        wr(1'b0, 8'hA5, 8'h18);
        // Guard overflows: manual, power-on, and no chip reset
        guard(1'b1, 1'b1);
        guard(1'b1, 1'b0);
        guard(1'b0, 1'b1);
        // Pin reset held across a guard overflow wins over it
        wr(1'b1, 8'h5A, 8'h5F);
        wr(1'b0, 8'hA5, 8'h78);
        pin_n = 1'b0;
        wr(1'b0, 8'h5A, 8'hFE);
        for (k = 0; k < 20 && ovf_n === 1'b1; k++) @(negedge clk);
        check(ovf_n, 1'b0);
        check(rst_req, 1'b0);
        rd(2'h3, v);
        check(v, rst_val(1'b0, 1'b1, 1'b0));
        pin_n = 1'b1;
        repeat (140) @(negedge clk);
        check(ovf_n, 1'b1);
        final_report();
    end
endmodule // overflow_guard_timer_tb
`default_nettype wire
